// ### shared/pmr_pkg.sv
package pmr_pkg;
  localparam int NUM_CH = 3;
  localparam int LEVEL_W = 6;
  localparam logic [7:0] CODE_ADDR [NUM_CH] = '{8'h80, 8'h90, 8'hA0};
  localparam logic [7:0] CTRL_ADDR [NUM_CH] = '{8'h81, 8'h91, 8'hA1};
  localparam logic [7:0] KA_ADDR = 8'hB1;
  localparam logic [7:0] BTN_ADDR = 8'hC0;
  localparam int EN_BIT = 7;
  localparam int DIS_BIT = 2;
  localparam int FIE_BIT = 1;
  localparam int PG_BIT = 0;
  localparam int PRESS_BIT = 7;
  localparam int RELEASE_BIT = 6;
  localparam int SREN_BIT = 1;
  localparam int PCEN_BIT = 0;
  localparam int BYTE_MSB = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] PTR_STEP = 8'h01;
  // Arbitrary bus address, overridden per board
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;
  localparam logic KA_EN_RST = 1'h1;

  typedef struct packed {
    logic enable;
    logic discharge_enable;
    logic fault_irq_enable;
    logic [LEVEL_W-1:0] output_level_code;
  } pmr_ctrl_type;

  typedef struct packed {
    logic enable;
    logic discharge;
    logic fault_irq;
    logic [LEVEL_W-1:0] output_level_code;
  } pmr_chan_out_type;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pmr_wr_type;

  localparam pmr_ctrl_type CTRL_RST = '0;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_ADDR = 3'h1,
    I2C_ACK_A = 3'h2,
    I2C_PTR = 3'h3,
    I2C_ACK_W = 3'h4,
    I2C_WDATA = 3'h5,
    I2C_RDATA = 3'h6,
    I2C_RACK = 3'h7
  } pmr_i2c_state_type;
endpackage

// ### rtl/pmr_sync.sv
`timescale 1ns/1ns
module pmr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
    end
  end

  assign sync_out = s2_r;
endmodule

// ### rtl/pmr_reg_channel.sv
`timescale 1ns/1ns
module pmr_reg_channel #(
  parameter logic [7:0] CODE_ADDR = pmr_pkg::CODE_ADDR[0],
  parameter logic [7:0] CTRL_ADDR = pmr_pkg::CTRL_ADDR[0]
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input pmr_pkg::pmr_wr_type wr,
  input wire logic [7:0] rd_addr,
  input wire logic power_good,
  input wire logic fault,
  output pmr_pkg::pmr_chan_out_type chan_out,
  output logic [7:0] rd_byte
);
  pmr_pkg::pmr_ctrl_type ctrl_r;
  pmr_pkg::pmr_ctrl_type ctrl_nxt;
  logic firq_r;
  logic firq_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr.en && wr.addr == CODE_ADDR) begin
      ctrl_nxt.output_level_code = wr.data[pmr_pkg::LEVEL_W-1:0];
    end
    if (wr.en && wr.addr == CTRL_ADDR) begin
      ctrl_nxt.enable = wr.data[pmr_pkg::EN_BIT];
      ctrl_nxt.discharge_enable = wr.data[pmr_pkg::DIS_BIT];
      ctrl_nxt.fault_irq_enable = wr.data[pmr_pkg::FIE_BIT];
    end
    firq_nxt = fault && ctrl_r.fault_irq_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= pmr_pkg::CTRL_RST;
      firq_r <= 1'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      firq_r <= firq_nxt;
    end
  end

  always_comb begin
    chan_out.enable = ctrl_r.enable;
    chan_out.discharge = ctrl_r.discharge_enable && !ctrl_r.enable;
    chan_out.fault_irq = firq_r;
    chan_out.output_level_code = ctrl_r.output_level_code;
  end

  // Reserved bits stay zero since nothing stores them
  always_comb begin
    rd_byte = '0;
    if (rd_addr == CODE_ADDR) begin
      rd_byte[pmr_pkg::LEVEL_W-1:0] = ctrl_r.output_level_code;
    end
    if (rd_addr == CTRL_ADDR) begin
      rd_byte[pmr_pkg::EN_BIT] = ctrl_r.enable;
      rd_byte[pmr_pkg::DIS_BIT] = ctrl_r.discharge_enable;
      rd_byte[pmr_pkg::FIE_BIT] = ctrl_r.fault_irq_enable;
      rd_byte[pmr_pkg::PG_BIT] = power_good;
    end
  end
endmodule

// ### rtl/pmr_regbank.sv
`timescale 1ns/1ns
module pmr_regbank #(
  parameter logic [6:0] DEV_ADDR = pmr_pkg::DEV_ADDR_DFLT,
  parameter logic KA_EN_RST = pmr_pkg::KA_EN_RST
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [pmr_pkg::NUM_CH-1:0] regulator_power_good,
  input wire logic [pmr_pkg::NUM_CH-1:0] regulator_fault,
  input wire logic push_button_input_n,
  input wire logic watchdog_expire,
  input wire logic sleep_entry,
  output pmr_pkg::pmr_chan_out_type [pmr_pkg::NUM_CH-1:0] chan_out,
  output logic keep_alive_enable,
  output logic regulator_fault_irq,
  output logic button_press_irq,
  output logic button_release_irq,
  output logic watchdog_soft_reset_start,
  output logic watchdog_power_cycle_start
);
  localparam int SYNC_W = 3 + pmr_pkg::NUM_CH;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_sync;
  logic scl_s;
  logic sda_s;
  logic btn_s;
  logic [pmr_pkg::NUM_CH-1:0] pg_s;

  // SCL, SDA, button and power-good pins share one synchroniser so their latency matches; regulator_fault is not synchronised
  assign pin_raw = {scl_in, sda_in, push_button_input_n, regulator_power_good};

  pmr_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(pin_raw),
    .sync_out(pin_sync)
  );

  assign scl_s = pin_sync[SYNC_W-1];
  assign sda_s = pin_sync[SYNC_W-2];
  assign btn_s = pin_sync[SYNC_W-3];
  assign pg_s = pin_sync[pmr_pkg::NUM_CH-1:0];

  pmr_pkg::pmr_i2c_state_type st_r;
  pmr_pkg::pmr_i2c_state_type st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic done_r;
  logic done_nxt;
  logic rw_r;
  logic rw_nxt;
  logic nack_r;
  logic nack_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic scl_d_r;
  logic scl_d_nxt;
  logic sda_d_r;
  logic sda_d_nxt;
  pmr_pkg::pmr_wr_type pend_r;
  pmr_pkg::pmr_wr_type pend_nxt;
  pmr_pkg::pmr_wr_type wr_r;
  pmr_pkg::pmr_wr_type wr_nxt;
  logic [7:0] rd_byte;

  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;

  // A written byte is held back and only committed once its transfer is over,
  // either by the next byte, a repeated start or the stop condition.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    pend_nxt = pend_r;
    oe_n_nxt = oe_n_r;
    scl_d_nxt = scl_s;
    sda_d_nxt = sda_s;
    wr_nxt = '0;
    if (bus_start || bus_stop) begin
      wr_nxt = pend_r;
      pend_nxt.en = 1'h0;
      st_nxt = bus_start ? pmr_pkg::I2C_ADDR : pmr_pkg::I2C_IDLE;
      cnt_nxt = '0;
      done_nxt = 1'h0;
      oe_n_nxt = 1'h1;
    end else begin
      unique case (st_r)
        pmr_pkg::I2C_IDLE: begin
          oe_n_nxt = 1'h1;
        end
        pmr_pkg::I2C_ADDR, pmr_pkg::I2C_PTR, pmr_pkg::I2C_WDATA: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[pmr_pkg::BYTE_MSB-1:0], sda_s};
            cnt_nxt = cnt_r + 3'h1;
            done_nxt = (cnt_r == pmr_pkg::BIT_LAST);
          end
          if (scl_fall && done_r) begin
            done_nxt = 1'h0;
            oe_n_nxt = 1'h0;
            st_nxt = pmr_pkg::I2C_ACK_W;
            if (st_r == pmr_pkg::I2C_ADDR) begin
              rw_nxt = sh_r[0];
              st_nxt = pmr_pkg::I2C_ACK_A;
              if (sh_r[pmr_pkg::BYTE_MSB:1] != DEV_ADDR) begin
                oe_n_nxt = 1'h1;
                st_nxt = pmr_pkg::I2C_IDLE;
              end
            end else if (st_r == pmr_pkg::I2C_PTR) begin
              ptr_nxt = sh_r;
            end else begin
              wr_nxt = pend_r;
              pend_nxt.en = 1'h1;
              pend_nxt.addr = ptr_r;
              pend_nxt.data = sh_r;
              ptr_nxt = ptr_r + pmr_pkg::PTR_STEP;
            end
          end
        end
        pmr_pkg::I2C_ACK_A: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            if (rw_r) begin
              sh_nxt = rd_byte;
              oe_n_nxt = rd_byte[pmr_pkg::BYTE_MSB];
              st_nxt = pmr_pkg::I2C_RDATA;
            end else begin
              oe_n_nxt = 1'h1;
              st_nxt = pmr_pkg::I2C_PTR;
            end
          end
        end
        pmr_pkg::I2C_ACK_W: begin
          if (scl_fall) begin
            oe_n_nxt = 1'h1;
            cnt_nxt = '0;
            st_nxt = pmr_pkg::I2C_WDATA;
          end
        end
        pmr_pkg::I2C_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 3'h1;
            done_nxt = (cnt_r == pmr_pkg::BIT_LAST);
          end
          if (scl_fall) begin
            if (done_r) begin
              done_nxt = 1'h0;
              oe_n_nxt = 1'h1;
              st_nxt = pmr_pkg::I2C_RACK;
            end else begin
              sh_nxt = {sh_r[pmr_pkg::BYTE_MSB-1:0], 1'h0};
              oe_n_nxt = sh_r[pmr_pkg::BYTE_MSB-1];
            end
          end
        end
        pmr_pkg::I2C_RACK: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
            if (!sda_s) begin
              ptr_nxt = ptr_r + pmr_pkg::PTR_STEP;
            end
          end
          if (scl_fall) begin
            cnt_nxt = '0;
            if (nack_r) begin
              st_nxt = pmr_pkg::I2C_IDLE;
            end else begin
              sh_nxt = rd_byte;
              oe_n_nxt = rd_byte[pmr_pkg::BYTE_MSB];
              st_nxt = pmr_pkg::I2C_RDATA;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= pmr_pkg::I2C_IDLE;
      cnt_r <= '0;
      done_r <= 1'h0;
      rw_r <= 1'h0;
      nack_r <= 1'h0;
      sh_r <= '0;
      ptr_r <= '0;
      pend_r <= '0;
      wr_r <= '0;
      oe_n_r <= 1'h1;
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      pend_r <= pend_nxt;
      wr_r <= wr_nxt;
      oe_n_r <= oe_n_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'h0;
  assign sda_oe_n = oe_n_r;

  logic [7:0] ch_rd [pmr_pkg::NUM_CH];

  for (genvar g = 0; g < pmr_pkg::NUM_CH; g++) begin : gen_ch
    pmr_reg_channel #(
      .CODE_ADDR(pmr_pkg::CODE_ADDR[g]),
      .CTRL_ADDR(pmr_pkg::CTRL_ADDR[g])
    ) u_ch (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .wr(wr_r),
      .rd_addr(ptr_r),
      .power_good(pg_s[g]),
      .fault(regulator_fault[g]),
      .chan_out(chan_out[g]),
      .rd_byte(ch_rd[g])
    );
  end

  logic ka_en_r;
  logic ka_en_nxt;
  logic press_en_r;
  logic press_en_nxt;
  logic release_en_r;
  logic release_en_nxt;
  logic sren_r;
  logic sren_nxt;
  logic pcen_r;
  logic pcen_nxt;
  logic btn_d_r;
  logic press_irq_r;
  logic press_irq_nxt;
  logic release_irq_r;
  logic release_irq_nxt;
  logic srst_r;
  logic srst_nxt;
  logic pcyc_r;
  logic pcyc_nxt;

  always_comb begin
    ka_en_nxt = ka_en_r;
    press_en_nxt = press_en_r;
    release_en_nxt = release_en_r;
    sren_nxt = sren_r;
    pcen_nxt = pcen_r;
    if (wr_r.en && wr_r.addr == pmr_pkg::KA_ADDR) begin
      ka_en_nxt = wr_r.data[pmr_pkg::EN_BIT];
    end
    if (wr_r.en && wr_r.addr == pmr_pkg::BTN_ADDR) begin
      press_en_nxt = wr_r.data[pmr_pkg::PRESS_BIT];
      release_en_nxt = wr_r.data[pmr_pkg::RELEASE_BIT];
      sren_nxt = wr_r.data[pmr_pkg::SREN_BIT];
      pcen_nxt = wr_r.data[pmr_pkg::PCEN_BIT];
    end
    // Sleep beats a same-cycle write so the watchdog never survives into sleep
    if (sleep_entry) begin
      sren_nxt = 1'h0;
      pcen_nxt = 1'h0;
    end
    // Input is active low: a falling level is a press
    press_irq_nxt = btn_d_r && !btn_s && press_en_r;
    release_irq_nxt = !btn_d_r && btn_s && release_en_r;
    srst_nxt = watchdog_expire && sren_r;
    pcyc_nxt = watchdog_expire && pcen_r;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ka_en_r <= KA_EN_RST;
      press_en_r <= 1'h0;
      release_en_r <= 1'h0;
      sren_r <= 1'h0;
      pcen_r <= 1'h0;
      btn_d_r <= 1'h1;
      press_irq_r <= 1'h0;
      release_irq_r <= 1'h0;
      srst_r <= 1'h0;
      pcyc_r <= 1'h0;
    end else begin
      ka_en_r <= ka_en_nxt;
      press_en_r <= press_en_nxt;
      release_en_r <= release_en_nxt;
      sren_r <= sren_nxt;
      pcen_r <= pcen_nxt;
      btn_d_r <= btn_s;
      press_irq_r <= press_irq_nxt;
      release_irq_r <= release_irq_nxt;
      srst_r <= srst_nxt;
      pcyc_r <= pcyc_nxt;
    end
  end

  always_comb begin
    rd_byte = '0;
    if (ptr_r == pmr_pkg::KA_ADDR) begin
      rd_byte[pmr_pkg::EN_BIT] = ka_en_r;
    end
    if (ptr_r == pmr_pkg::BTN_ADDR) begin
      rd_byte[pmr_pkg::PRESS_BIT] = press_en_r;
      rd_byte[pmr_pkg::RELEASE_BIT] = release_en_r;
      rd_byte[pmr_pkg::SREN_BIT] = sren_r;
      rd_byte[pmr_pkg::PCEN_BIT] = pcen_r;
    end
    for (int i = 0; i < pmr_pkg::NUM_CH; i++) begin
      rd_byte = rd_byte | ch_rd[i];
    end
    regulator_fault_irq = 1'h0;
    for (int i = 0; i < pmr_pkg::NUM_CH; i++) begin
      regulator_fault_irq = regulator_fault_irq | chan_out[i].fault_irq;
    end
  end

  assign keep_alive_enable = ka_en_r;
  assign button_press_irq = press_irq_r;
  assign button_release_irq = release_irq_r;
  assign watchdog_soft_reset_start = srst_r;
  assign watchdog_power_cycle_start = pcyc_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence pg_steady;
    $stable(regulator_power_good[0]) [*3];
  endsequence

  sequence btn_fall;
    btn_s ##1 !btn_s;
  endsequence

  property level_p;
    logic [pmr_pkg::LEVEL_W-1:0] v;
    (wr_r.en && wr_r.addr == pmr_pkg::CODE_ADDR[0], v = wr_r.data[pmr_pkg::LEVEL_W-1:0])
      |=> chan_out[0].output_level_code == v;
  endproperty

  level_write_a: assert property (level_p)
    else $error("level code not taken from write");
  enable_on_a: assert property (
    wr_r.en && wr_r.addr == pmr_pkg::CTRL_ADDR[1] && wr_r.data[pmr_pkg::EN_BIT]
      |=> chan_out[1].enable)
    else $error("regulator enable not set by write");
  enable_hold_a: assert property (
    !(wr_r.en && wr_r.addr == pmr_pkg::CTRL_ADDR[1]) |=> $stable(chan_out[1].enable))
    else $error("regulator enable changed without write");
  discharge_off_a: assert property (
    wr_r.en && wr_r.addr == pmr_pkg::CTRL_ADDR[2] && wr_r.data[pmr_pkg::DIS_BIT]
      && !wr_r.data[pmr_pkg::EN_BIT] |=> chan_out[2].discharge && !chan_out[2].enable)
    else $error("discharge not active while off");
  fault_gate_a: assert property (
    chan_out[0].fault_irq |-> $past(regulator_fault[0]))
    else $error("fault interrupt without fault");
  power_good_a: assert property (
    pg_steady ##0 (ptr_r == pmr_pkg::CTRL_ADDR[0])
      |-> rd_byte[pmr_pkg::PG_BIT] == regulator_power_good[0])
    else $error("power good readback wrong");
  ka_reserved_a: assert property (
    ptr_r == pmr_pkg::KA_ADDR |-> rd_byte[pmr_pkg::EN_BIT-1:0] == '0)
    else $error("keep-alive reserved bits not zero");
  press_irq_a: assert property (
    btn_fall ##0 press_en_r |=> button_press_irq)
    else $error("press interrupt missing");
  release_irq_a: assert property (
    button_release_irq |-> $past(btn_s) && !$past(btn_s, 2) && $past(release_en_r))
    else $error("release interrupt without cause");
  soft_reset_a: assert property (
    watchdog_soft_reset_start |-> $past(watchdog_expire) && $past(sren_r))
    else $error("soft reset without armed expiry");
  sleep_clear_a: assert property (
    sleep_entry |=> !sren_r && !pcen_r)
    else $error("watchdog enables survive sleep");
  btn_reserved_a: assert property (
    ptr_r == pmr_pkg::BTN_ADDR |-> rd_byte[pmr_pkg::RELEASE_BIT-1:pmr_pkg::SREN_BIT+1] == '0)
    else $error("button reserved bits not zero");
  power_cycle_a: assert property (
    watchdog_expire && pcen_r |=> watchdog_power_cycle_start)
    else $error("power cycle not started");
  write_commit_a: assert property (
    wr_r.en |-> $past(bus_start || bus_stop || (scl_fall && done_r)))
    else $error("write committed mid transfer");
endmodule

// ### tb/pmr_host_model.sv
`timescale 1ns/1ns
module pmr_host_model #(
  parameter logic [6:0] DEV_ADDR = pmr_pkg::DEV_ADDR_DFLT
) (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Four-cycle phases leave margin over the synchroniser delay
  task automatic put_bit(input logic b, output logic got);
    cyc(4);
    sda_o = b;
    cyc(4);
    scl_o = 1'h1;
    cyc(4);
    got = sda_line;
    cyc(4);
    scl_o = 1'h0;
  endtask
  task automatic start_c;
    cyc(4);
    sda_o = 1'h1;
    cyc(4);
    scl_o = 1'h1;
    cyc(8);
    sda_o = 1'h0;
    cyc(8);
    scl_o = 1'h0;
  endtask
  task automatic stop_c;
    cyc(4);
    sda_o = 1'h0;
    cyc(4);
    scl_o = 1'h1;
    cyc(8);
    sda_o = 1'h1;
    cyc(8);
  endtask
  // Sending 8'hFF releases the line so the device can drive read data
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(ack_in, ack);
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    start_c();
    xfer({DEV_ADDR, 1'h0}, 1'h1, rx, a0);
    xfer(addr, 1'h1, rx, a1);
    xfer(data, 1'h1, rx, a2);
    stop_c();
    ok = ~(a0 | a1 | a2);
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start_c();
    xfer({DEV_ADDR, 1'h0}, 1'h1, rx, a0);
    xfer(addr, 1'h1, rx, a1);
    start_c();
    xfer({DEV_ADDR, 1'h1}, 1'h1, rx, a2);
    xfer(8'hFF, 1'h1, data, a3);
    stop_c();
    ok = ~(a0 | a1 | a2);
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'h0;
  logic sys_rst;
  logic scl_o;
  logic sda_o;
  logic sda_out;
  logic sda_oe_n;
  logic [pmr_pkg::NUM_CH-1:0] pg;
  logic [pmr_pkg::NUM_CH-1:0] flt;
  logic btn_n;
  logic expire;
  logic sleep;
  pmr_pkg::pmr_chan_out_type [pmr_pkg::NUM_CH-1:0] chan_out;
  logic ka_en;
  logic fault_irq;
  logic press_irq;
  logic release_irq;
  logic sr_start;
  logic pc_start;
  wire sda_line = sda_o & (sda_oe_n | sda_out);
  int n_mismatch = 0;
  int checked = 0;

  always #5 ref_clk = ~ref_clk;

  pmr_regbank uut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .scl_in(scl_o),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .regulator_power_good(pg),
    .regulator_fault(flt),
    .push_button_input_n(btn_n),
    .watchdog_expire(expire),
    .sleep_entry(sleep),
    .chan_out(chan_out),
    .keep_alive_enable(ka_en),
    .regulator_fault_irq(fault_irq),
    .button_press_irq(press_irq),
    .button_release_irq(release_irq),
    .watchdog_soft_reset_start(sr_start),
    .watchdog_power_cycle_start(pc_start)
  );
  pmr_host_model host (
    .ref_clk(ref_clk),
    .sda_line(sda_line),
    .scl_o(scl_o),
    .sda_o(sda_o)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(a, d, ok);
    host.cyc(4);
    check(8'(ok), 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic ok;
    host.read_reg(a, d, ok);
    check(8'(ok), 8'h01);
  endtask
  task automatic count_irq(output int np, output int nr);
    np = 0;
    nr = 0;
    repeat (12) begin
      host.cyc(1);
      np += int'(press_irq === 1'h1);
      nr += int'(release_irq === 1'h1);
    end
  endtask
  // The start pulses stand for the one cycle right after the expiry edge
  task automatic pulse_expire(output logic s, output logic p);
    expire = 1'h1;
    host.cyc(1);
    s = sr_start;
    p = pc_start;
    expire = 1'h0;
    host.cyc(1);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    rd(8'h80, d);
    check(d, 8'h00);
    rd(8'hA1, d);
    check(d, 8'h00);
    rd(pmr_pkg::KA_ADDR, d);
    check(d, 8'h80);
    rd(pmr_pkg::BTN_ADDR, d);
    check(d, 8'h00);
    rd(8'h50, d);
    check(d, 8'h00);
    check(8'(ka_en), 8'h01);
    $display("test reset done");
  endtask
  task automatic t_channels;
    logic [7:0] d;
    for (int i = 0; i < pmr_pkg::NUM_CH; i++) begin
      pg[i] = 1'h1;
      wr(pmr_pkg::CODE_ADDR[i], 8'hFF);
      rd(pmr_pkg::CODE_ADDR[i], d);
      check(d, 8'h3F);
      check(8'(chan_out[i].output_level_code), 8'h3F);
      wr(pmr_pkg::CTRL_ADDR[i], 8'hFE);
      rd(pmr_pkg::CTRL_ADDR[i], d);
      check(d, 8'h87);
      check(8'(chan_out[i].enable), 8'h01);
      check(8'(chan_out[i].discharge), 8'h00);
      flt[i] = 1'h1;
      host.cyc(3);
      check(8'(fault_irq), 8'h01);
      wr(pmr_pkg::CTRL_ADDR[i], 8'h04);
      pg[i] = 1'h0;
      host.cyc(4);
      rd(pmr_pkg::CTRL_ADDR[i], d);
      check(d, 8'h04);
      check(8'(chan_out[i].discharge), 8'h01);
      check(8'(fault_irq), 8'h00);
      wr(pmr_pkg::CTRL_ADDR[i], 8'h00);
      check(8'(chan_out[i].discharge), 8'h00);
      check(8'(chan_out[i].enable), 8'h00);
      flt[i] = 1'h0;
    end
    $display("test channels done");
  endtask
  task automatic t_keep_alive;
    logic [7:0] d;
    wr(pmr_pkg::KA_ADDR, 8'h7F);
    rd(pmr_pkg::KA_ADDR, d);
    check(d, 8'h00);
    check(8'(ka_en), 8'h00);
    wr(pmr_pkg::KA_ADDR, 8'hFF);
    rd(pmr_pkg::KA_ADDR, d);
    check(d, 8'h80);
    check(8'(ka_en), 8'h01);
    $display("test keep_alive done");
  endtask
  task automatic t_button;
    logic [7:0] d;
    int np;
    int nr;
    wr(pmr_pkg::BTN_ADDR, 8'hFF);
    rd(pmr_pkg::BTN_ADDR, d);
    check(d, 8'hC3);
    btn_n = 1'h0;
    count_irq(np, nr);
    check(8'(np), 8'h01);
    check(8'(nr), 8'h00);
    btn_n = 1'h1;
    count_irq(np, nr);
    check(8'(np), 8'h00);
    check(8'(nr), 8'h01);
    wr(pmr_pkg::BTN_ADDR, 8'h00);
    btn_n = 1'h0;
    count_irq(np, nr);
    check(8'(np), 8'h00);
    btn_n = 1'h1;
    count_irq(np, nr);
    check(8'(nr), 8'h00);
    $display("test button done");
  endtask
  task automatic t_watchdog;
    logic [7:0] d;
    logic s;
    logic p;
    wr(pmr_pkg::BTN_ADDR, 8'h02);
    pulse_expire(s, p);
    check({7'h00, s}, 8'h01);
    check({7'h00, p}, 8'h00);
    wr(pmr_pkg::BTN_ADDR, 8'h01);
    pulse_expire(s, p);
    check({7'h00, s}, 8'h00);
    check({7'h00, p}, 8'h01);
    wr(pmr_pkg::BTN_ADDR, 8'h03);
    sleep = 1'h1;
    host.cyc(1);
    sleep = 1'h0;
    host.cyc(1);
    rd(pmr_pkg::BTN_ADDR, d);
    check(d, 8'h00);
    pulse_expire(s, p);
    check({6'h00, s, p}, 8'h00);
    $display("test watchdog done");
  endtask
  task automatic t_refused;
    logic [7:0] rx;
    logic a;
    logic [7:0] d;
    host.start_c();
    host.xfer({pmr_pkg::DEV_ADDR_DFLT ^ 7'h01, 1'h0}, 1'h1, rx, a);
    check({7'h00, a}, 8'h01);
    host.xfer(pmr_pkg::CODE_ADDR[0], 1'h1, rx, a);
    host.xfer(8'h00, 1'h1, rx, a);
    host.stop_c();
    host.cyc(4);
    rd(pmr_pkg::CODE_ADDR[0], d);
    check(d, 8'h3F);
    wr(8'h50, 8'hFF);
    rd(8'h50, d);
    check(d, 8'h00);
    // Mid-run reset must bring the written level code back to zero
    sys_rst = 1'h1;
    host.cyc(3);
    sys_rst = 1'h0;
    host.cyc(4);
    rd(pmr_pkg::CODE_ADDR[0], d);
    check(d, 8'h00);
    check(8'(ka_en), 8'h01);
    $display("test refused done");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'h1;
    pg = '0;
    flt = '0;
    btn_n = 1'h1;
    expire = 1'h0;
    sleep = 1'h0;
    repeat (12) @(posedge ref_clk);
    #1;
    sys_rst = 1'h0;
    host.cyc(4);
    t_reset();
    t_channels();
    t_keep_alive();
    t_button();
    t_watchdog();
    t_refused();
    tally_and_finish();
  end
  // About 45 transfers of under a thousand cycles each fit well inside this span
  initial begin
    #600000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
